// *** verilog/ocfc_pkg.sv ***
// What this block does
// - Every analog PLL output clock stays locked to the transmit DPLL.
// - Synthesizer source bit selects transmit or receive DPLL feed.
// - Single-ended clock frequency comes from a four-bit code register.
// - Run register picks telecom or Ethernet plan; telecom after reset.
// - Telecom single-ended codes decode to the listed SONET rates.
// - Ethernet low-speed single-ended codes decode to listed rates.
// - Differential frequency comes from a three-bit code per active plan.
// - Telecom differential codes decode to 6.48 through 622.08 MHz.
// - In Ethernet mode group bit one is low speed, zero high speed.
// - Ethernet differential codes decode per low or high speed group.
// - Programmable clock equals 16-bit multiplier times 8 kHz.
// - Multiplier zero gives a 2 kHz programmable clock.
// - Frame pulse rate comes from a four-bit rate code register.
// - Rate codes decode to 166.6667 Hz through 64 kHz and 1 Hz.
// - Frame pulse width comes from a three-bit width field.
// - Width codes 000 to 100 give one period of 4.096-65.536 MHz.
// - Width 111 gives one programmable clock period; 101, 110 reserved.
// - Shape register also selects style, aligning edge and polarity.
package ocfc_pkg;
    localparam logic [6:0] SYN_EN_ADDR  = 7'h36;
    localparam logic [6:0] MULT_LO_ADDR = 7'h38;
    localparam logic [6:0] MULT_HI_ADDR = 7'h39;
    localparam logic [6:0] FP_RATE_ADDR = 7'h3E;
    localparam logic [6:0] FP_SHP_ADDR  = 7'h3F;
    localparam logic [6:0] RUN_ADDR     = 7'h51;
    localparam logic [6:0] SE_SEL_ADDR  = 7'h52;
    localparam logic [6:0] DIFF_ADDR    = 7'h61;
    localparam logic [7:0] REG_RST      = 8'h00;
    // Field positions
    localparam int SRC_BIT   = 0;  // synth enable: 1 = receive DPLL
    localparam int ETH_BIT   = 0;  // run register
    localparam int FSEL_BIT  = 1;
    localparam int FSELD_BIT = 2;
    localparam int STYLE_BIT = 3;  // shape: 1 = 50% clock
    localparam int EDGE_BIT  = 4;  // shape: 1 = falling edge
    localparam int POL_BIT   = 5;  // shape: 1 = negative
    localparam logic [2:0] W_PCLK = 3'h7;
    localparam int MCLK_NS   = 5;
    localparam int KHZ8_HZ   = 8000;
    localparam int N0_HZ     = 2000;
    localparam int PCLK_CYC0 = 1000000000 / (N0_HZ * MCLK_NS);
    localparam int PCLK_KCYC = 1000000000 / (KHZ8_HZ * MCLK_NS);
    // Width codes 000..100 in ps, one period of 4.096 * 2^k MHz
    localparam int W0_PS = 244141;
    localparam int WPS_CYC = MCLK_NS * 1000;
endpackage : ocfc_pkg

// *** verilog/ocfc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocfc_top #(
    parameter int FP_NS_PER_CYC = ocfc_pkg::MCLK_NS
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             apll_src_tx,
    output logic             synth_src_rx,
    output logic      [31:0] se_freq_hz,
    output logic             se_valid,
    output logic      [31:0] diff_freq_hz,
    output logic             diff_valid,
    output logic      [31:0] synth_freq_hz,
    output logic      [31:0] fp_period_ns,
    output logic             frame_pulse_out
);
    import ocfc_pkg::*;

    // Single-ended code decode, Hz; 0 marks reserved
    function automatic logic [31:0] se_hz(input logic eth,
                                          input logic [3:0] c);
        se_hz = 32'h0;
        if (!eth) begin
            unique case (c)
                4'h2: se_hz = 32'd77760000;
                4'h3: se_hz = 32'd38880000;
                4'h4: se_hz = 32'd19440000;
                4'h5: se_hz = 32'd9720000;
                4'hA: se_hz = 32'd51840000;
                4'hB: se_hz = 32'd25920000;
                4'hC: se_hz = 32'd12960000;
                4'hD: se_hz = 32'd6480000;
                default: se_hz = 32'h0;
            endcase
        end else begin
            unique case (c)
                4'h1: se_hz = 32'd125000000;
                4'h2: se_hz = 32'd62500000;
                4'h5: se_hz = 32'd50000000;
                4'h6: se_hz = 32'd25000000;
                4'h7: se_hz = 32'd12500000;
                default: se_hz = 32'h0;
            endcase
        end
    endfunction : se_hz

    // Differential decode, Hz; 0 marks reserved
    function automatic logic [31:0] diff_hz(input logic eth,
                                            input logic lo,
                                            input logic [2:0] c);
        logic [31:0] t [8];
        logic [31:0] l [8];
        t = '{32'd19440000, 32'd38880000, 32'd77760000, 32'd155520000,
              32'd311040000, 32'd622080000, 32'd6480000, 32'd51840000};
        l = '{32'h0, 32'd125000000, 32'd62500000, 32'h0, 32'h0,
              32'd50000000, 32'd25000000, 32'd12500000};
        if (!eth)
            diff_hz = t[c];
        else if (lo)
            diff_hz = l[c];
        else if (c == 3'h3)
            diff_hz = 32'd156250000;
        else if (c == 3'h4)
            diff_hz = 32'd312500000;
        else
            diff_hz = 32'h0;
    endfunction : diff_hz

    // Frame repetition period in ns; 0 marks reserved
    function automatic logic [31:0] fp_ns(input logic [3:0] c);
        unique case (c)
            4'h0: fp_ns = 32'd6000000;
            4'h1: fp_ns = 32'd2500000;
            4'h2: fp_ns = 32'd1000000;
            4'h3: fp_ns = 32'd500000;
            4'h4: fp_ns = 32'd250000;
            4'h5: fp_ns = 32'd125000;
            4'h6: fp_ns = 32'd31250;
            4'h7: fp_ns = 32'd15625;
            4'h8: fp_ns = 32'd1000000000;
            default: fp_ns = 32'h0;
        endcase
    endfunction : fp_ns

    logic [7:0]  syn_en_reg, mult_lo_reg, mult_hi_reg, fp_rate_reg;
    logic [7:0]  fp_shp_reg, run_reg, se_sel_reg, diff_reg;
    logic [31:0] cnt_reg;
    logic        fp_reg;

    // Write strobes per register
    wire w_syn  = reg_wr && reg_addr == SYN_EN_ADDR;
    wire w_mlo  = reg_wr && reg_addr == MULT_LO_ADDR;
    wire w_mhi  = reg_wr && reg_addr == MULT_HI_ADDR;
    wire w_rate = reg_wr && reg_addr == FP_RATE_ADDR;
    wire w_shp  = reg_wr && reg_addr == FP_SHP_ADDR;
    wire w_run  = reg_wr && reg_addr == RUN_ADDR;
    wire w_se   = reg_wr && reg_addr == SE_SEL_ADDR;
    wire w_diff = reg_wr && reg_addr == DIFF_ADDR;

    // Plain host register file; all fields reset to telecom, Tx source
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            syn_en_reg  <= REG_RST;
            mult_lo_reg <= REG_RST;
            mult_hi_reg <= REG_RST;
            fp_rate_reg <= REG_RST;
            fp_shp_reg  <= REG_RST;
            run_reg     <= REG_RST;
            se_sel_reg  <= REG_RST;
            diff_reg    <= REG_RST;
        end else begin
            if (w_syn)  syn_en_reg  <= reg_wdata;
            if (w_mlo)  mult_lo_reg <= reg_wdata;
            if (w_mhi)  mult_hi_reg <= reg_wdata;
            if (w_rate) fp_rate_reg <= reg_wdata;
            if (w_shp)  fp_shp_reg  <= reg_wdata;
            if (w_run)  run_reg     <= reg_wdata;
            if (w_se)   se_sel_reg  <= reg_wdata;
            if (w_diff) diff_reg    <= reg_wdata;
        end
    end

    // Read mux; unmapped offsets read zero
    logic [7:0] rd_next;
    always_comb begin
        unique case (reg_addr)
            SYN_EN_ADDR:  rd_next = syn_en_reg;
            MULT_LO_ADDR: rd_next = mult_lo_reg;
            MULT_HI_ADDR: rd_next = mult_hi_reg;
            FP_RATE_ADDR: rd_next = fp_rate_reg;
            FP_SHP_ADDR:  rd_next = fp_shp_reg;
            RUN_ADDR:     rd_next = run_reg;
            SE_SEL_ADDR:  rd_next = se_sel_reg;
            DIFF_ADDR:    rd_next = diff_reg;
            default:      rd_next = 8'h00;
        endcase
    end

    // Frequency plan decode
    wire        eth      = run_reg[ETH_BIT];
    wire [3:0]  se_code  = se_sel_reg[3:0];
    wire [2:0]  df_code  = diff_reg[2:0];
    wire [15:0] mult     = {mult_hi_reg, mult_lo_reg};
    wire [31:0] se_next  = se_hz(eth, se_code);
    wire [31:0] df_next  = diff_hz(eth, run_reg[FSELD_BIT], df_code);
    wire [31:0] syn_next = (mult == 16'h0) ? 32'(N0_HZ)
                         : 32'(mult) * 32'(KHZ8_HZ);
    wire [31:0] per_ns   = fp_ns(fp_rate_reg[3:0]);

    // Frame pulse timing in mclk cycles
    wire [2:0]  wcode    = fp_shp_reg[2:0];
    wire        style50  = fp_shp_reg[STYLE_BIT];
    wire        falling  = fp_shp_reg[EDGE_BIT];
    wire        neg      = fp_shp_reg[POL_BIT];
    wire [31:0] per_cyc  = per_ns / 32'(FP_NS_PER_CYC);
    wire [31:0] e1_cyc   = 32'((W0_PS >> wcode) / WPS_CYC);
    wire [31:0] pclk_cyc = (mult == 16'h0) ? 32'(PCLK_CYC0)
                         : 32'(PCLK_KCYC) / 32'(mult);
    wire [31:0] clk_cyc  = (wcode == W_PCLK) ? pclk_cyc : e1_cyc;
    wire [31:0] w_raw    = style50 ? (per_cyc >> 1) : clk_cyc;
    wire [31:0] w_cyc    = (w_raw == 32'h0) ? 32'h1 : w_raw;
    // Falling alignment lands half an associated clock period later
    wire [31:0] off_cyc  = falling ? (clk_cyc >> 1) : 32'h0;
    wire        w_ok     = wcode <= 3'h4 || wcode == W_PCLK;
    wire        fp_ok    = per_ns != 32'h0 && w_ok;
    wire        cnt_wrap = cnt_reg + 32'h1 >= per_cyc;
    wire [31:0] cnt_next = (!fp_ok || cnt_wrap) ? 32'h0
                         : cnt_reg + 32'h1;
    wire        in_pulse = cnt_reg >= off_cyc
                        && cnt_reg <  off_cyc + w_cyc;
    // Reserved settings hold the pin low instead of inverting
    wire        fp_next  = fp_ok && (in_pulse ^ neg);

    // Decoded outputs and frame pulse counter, all registered
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata     <= 8'h00;
            apll_src_tx   <= 1'b1;
            synth_src_rx  <= 1'b0;
            se_freq_hz    <= 32'h0;
            se_valid      <= 1'b0;
            diff_freq_hz  <= 32'h0;
            diff_valid    <= 1'b0;
            synth_freq_hz <= 32'h0;
            fp_period_ns  <= 32'h0;
            cnt_reg       <= 32'h0;
            fp_reg        <= 1'b0;
        end else begin
            reg_rdata     <= reg_rd ? rd_next : 8'h00;
            apll_src_tx   <= 1'b1;
            synth_src_rx  <= syn_en_reg[SRC_BIT];
            se_freq_hz    <= se_next;
            se_valid      <= se_next != 32'h0;
            diff_freq_hz  <= df_next;
            diff_valid    <= df_next != 32'h0;
            synth_freq_hz <= syn_next;
            fp_period_ns  <= per_ns;
            cnt_reg       <= cnt_next;
            fp_reg        <= fp_next;
        end
    end
    assign frame_pulse_out = fp_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Source selection and register path
    src_sel_a: assert property (w_syn |=> ##1
        synth_src_rx == $past(reg_wdata[SRC_BIT], 2))
        else $error("synth source not following write");

    apll_tx_a: assert property (apll_src_tx)
        else $error("analog PLL left transmit DPLL");

    rd_data_a: assert property (reg_rd && reg_addr == SYN_EN_ADDR
        && !w_syn |=> reg_rdata == $past(syn_en_reg))
        else $error("source register read back wrong");

    // Single-ended decode per plan
    se_tel_a: assert property (w_se && reg_wdata[3:0] == 4'h2 && !eth
        && !w_run |=> ##1 se_freq_hz == 32'd77760000)
        else $error("telecom single-ended 0010 wrong");

    se_tel6_a: assert property (!eth && se_code == 4'hD
        |=> se_freq_hz == 32'd6480000)
        else $error("telecom single-ended 1101 wrong");

    se_res_a: assert property (!eth && se_code == 4'h1
        |=> !se_valid)
        else $error("telecom reserved code marked valid");

    se_eth_a: assert property (w_se && reg_wdata[3:0] == 4'h1 && eth
        && !w_run |=> ##1 se_freq_hz == 32'd125000000)
        else $error("Ethernet single-ended 0001 wrong");

    se_eth7_a: assert property (eth && se_code == 4'h7
        |=> se_freq_hz == 32'd12500000)
        else $error("Ethernet single-ended 0111 wrong");

    // Differential decode per plan and group
    diff_hs_a: assert property (eth && !run_reg[FSELD_BIT]
        && df_code == 3'h3 |=> diff_freq_hz == 32'd156250000)
        else $error("high-speed differential 011 wrong");

    diff_hs4_a: assert property (eth && !run_reg[FSELD_BIT]
        && df_code == 3'h4 |=> diff_freq_hz == 32'd312500000)
        else $error("high-speed differential 100 wrong");

    diff_ls_a: assert property (eth && run_reg[FSELD_BIT]
        && df_code == 3'h1 |=> diff_freq_hz == 32'd125000000)
        else $error("low-speed differential 001 wrong");

    diff_lres_a: assert property (eth && run_reg[FSELD_BIT]
        && df_code == 3'h0 |=> !diff_valid)
        else $error("low-speed reserved code marked valid");

    diff_tel_a: assert property (!eth && df_code == 3'h5
        |=> diff_freq_hz == 32'd622080000)
        else $error("telecom differential 101 wrong");

    diff_tel0_a: assert property (!eth && df_code == 3'h0
        |=> diff_freq_hz == 32'd19440000)
        else $error("telecom differential 000 wrong");

    diff_tel4_a: assert property (!eth && df_code == 3'h4
        |=> diff_freq_hz == 32'd311040000)
        else $error("telecom differential 100 wrong");

    // Programmable clock frequency
    mult_zero_a: assert property (mult == 16'h0
        |=> synth_freq_hz == 32'd2000)
        else $error("zero multiplier not 2 kHz");

    mult_scale_a: assert property (mult != 16'h0 |=>
        synth_freq_hz == 32'($past(mult)) * 32'd8000)
        else $error("programmable clock not N times 8 kHz");

    // Frame pulse rate and shape
    rate_dec_a: assert property (fp_rate_reg[3:0] == 4'h8
        |=> fp_period_ns == 32'd1000000000)
        else $error("rate code 1000 not 1 Hz");

    rate_8k_a: assert property (fp_rate_reg[3:0] == 4'h5
        |=> fp_period_ns == 32'd125000)
        else $error("rate code 0101 not 8 kHz");

    rate_res_a: assert property (fp_rate_reg[3:0] == 4'h9
        |=> fp_period_ns == 32'h0)
        else $error("reserved rate code not marked");

    resv_low_a: assert property (wcode == 3'h5 && !w_shp
        |=> ##1 !frame_pulse_out)
        else $error("reserved width not holding pulse low");

    fp_hold_a: assert property (!fp_ok
        |=> cnt_reg == 32'h0 && !frame_pulse_out)
        else $error("reserved setting left counter running");

    // Shape written mid-pulse may cut it short, so hosts settle first
    pulse_len_a: assert property ($rose(fp_reg) && !neg && !style50
        && wcode == 3'h0 && $stable(fp_shp_reg) |-> fp_reg[*8])
        else $error("4.096 MHz width pulse too short");
endmodule : ocfc_top
`default_nettype wire

// *** bench/ocfc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocfc_host (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output logic      [6:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    // Idle bus at time zero
    initial begin
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One write, then one extra cycle so decoded outputs have landed
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a == 7'h39 && d > 8'h2F) d = 8'h2F;
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;  // Stale data must not look valid
        @(negedge mclk);
    endtask : wr
    // Read data stands one cycle only, so take it at the next negedge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        d = reg_rdata;
        reg_rd = 1'b0;
    endtask : rd
endmodule : ocfc_host
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ocfc_pkg::*;
    typedef struct packed {
        logic [7:0]  run;
        logic [3:0]  se;
        logic [2:0]  df;
        logic [31:0] xse;
        logic [31:0] xdf;
    } ocfc_row_t;
    logic        mclk, rst_n, reg_wr, reg_rd, apll_src_tx, synth_src_rx;
    logic        se_valid, diff_valid, frame_pulse_out;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rv;
    logic [31:0] se_freq_hz, diff_freq_hz, synth_freq_hz, fp_period_ns;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          act, per;
    // Plan, codes, expected single-ended and differential Hz
    ocfc_row_t rows [17] = '{
        '{8'h00, 4'h2, 3'h0, 32'd77760000, 32'd19440000},
        '{8'h00, 4'h3, 3'h1, 32'd38880000, 32'd38880000},
        '{8'h00, 4'h4, 3'h2, 32'd19440000, 32'd77760000},
        '{8'h00, 4'h5, 3'h3, 32'd9720000, 32'd155520000},
        '{8'h00, 4'hA, 3'h4, 32'd51840000, 32'd311040000},
        '{8'h00, 4'hB, 3'h5, 32'd25920000, 32'd622080000},
        '{8'h00, 4'hC, 3'h6, 32'd12960000, 32'd6480000},
        '{8'h00, 4'hD, 3'h7, 32'd6480000, 32'd51840000},
        '{8'h00, 4'h1, 3'h0, 32'h0, 32'd19440000},
        '{8'h07, 4'h1, 3'h1, 32'd125000000, 32'd125000000},
        '{8'h07, 4'h2, 3'h2, 32'd62500000, 32'd62500000},
        '{8'h07, 4'h5, 3'h5, 32'd50000000, 32'd50000000},
        '{8'h07, 4'h6, 3'h6, 32'd25000000, 32'd25000000},
        '{8'h07, 4'h7, 3'h7, 32'd12500000, 32'd12500000},
        '{8'h07, 4'h3, 3'h0, 32'h0, 32'h0},
        '{8'h01, 4'h1, 3'h3, 32'd125000000, 32'd156250000},
        '{8'h01, 4'h2, 3'h4, 32'd62500000, 32'd312500000}};
    logic [31:0] fp_x [10] = '{32'd6000000, 32'd2500000, 32'd1000000,
        32'd500000, 32'd250000, 32'd125000, 32'd31250, 32'd15625,
        32'd1000000000, 32'h0};

    ocfc_top dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .apll_src_tx, .synth_src_rx, .se_freq_hz, .se_valid,
        .diff_freq_hz, .diff_valid, .synth_freq_hz, .fp_period_ns,
        .frame_pulse_out);
    ocfc_host host (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd);

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Hang guard, well above the roughly 45k cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Active run length and period from one active-level start to the next, bounded by k
    task automatic meas(input logic lvl);
        int k;
        k = 0;
        act = 0;
        per = 0;
        while (frame_pulse_out === lvl && k < 8000) begin
            @(negedge mclk);
            k++;
        end
        while (frame_pulse_out !== lvl && k < 8000) begin
            @(negedge mclk);
            k++;
        end
        while (frame_pulse_out === lvl && k < 8000) begin
            @(negedge mclk);
            k++;
            act++;
            per++;
        end
        while (frame_pulse_out !== lvl && per > 0 && k < 8000) begin
            @(negedge mclk);
            k++;
            per++;
        end
    endtask : meas
    task automatic shp(input logic [7:0] v, input logic lvl,
                       input logic [31:0] xa, input logic [31:0] xp);
        repeat (100) @(negedge mclk);
        host.wr(FP_SHP_ADDR, v);
        meas(lvl);
        chk(32'(act), xa);
        chk(32'(per), xp);
    endtask : shp
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report

    initial begin
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        // All-zero registers after reset
        chk({24'h0, reg_rdata}, 32'h0);
        chk({31'h0, apll_src_tx}, 32'h1);
        chk(diff_freq_hz, 32'd19440000);
        chk(synth_freq_hz, 32'd2000);
        chk(fp_period_ns, 32'd6000000);
        chk({31'h0, se_valid}, 32'h0);
        foreach (rows[i]) begin
            host.wr(RUN_ADDR, rows[i].run);
            host.wr(SE_SEL_ADDR, {4'h0, rows[i].se});
            host.wr(DIFF_ADDR, {5'h0, rows[i].df});
            chk(se_freq_hz, rows[i].xse);
            chk({31'h0, se_valid}, {31'h0, rows[i].xse != 0});
            chk(diff_freq_hz, rows[i].xdf);
            chk({31'h0, diff_valid}, {31'h0, rows[i].xdf != 0});
        end
        // Code 9 is reserved and reads back as zero period
        for (int r = 0; r < 10; r++) begin
            host.wr(FP_RATE_ADDR, 8'(r));
            chk(fp_period_ns, fp_x[r]);
        end
        host.wr(SYN_EN_ADDR, 8'h01);
        chk({31'h0, synth_src_rx}, 32'h1);
        host.rd(SYN_EN_ADDR, rv);
        chk({24'h0, rv}, 32'h1);
        host.rd(7'h00, rv);
        chk({24'h0, rv}, 32'h0);
        host.wr(SYN_EN_ADDR, 8'h00);
        chk({31'h0, synth_src_rx}, 32'h0);
        chk({31'h0, apll_src_tx}, 32'h1);
        // Low byte alone is visible before the high byte lands
        host.wr(MULT_LO_ADDR, 8'h10);
        chk(synth_freq_hz, 32'd128000);
        host.wr(MULT_HI_ADDR, 8'h01);
        chk(synth_freq_hz, 32'd2176000);
        host.wr(FP_RATE_ADDR, 8'h07);
        shp(8'h00, 1'b1, 48, 3125);
        shp(8'h02, 1'b1, 12, 3125);
        shp(8'h20, 1'b0, 48, 3125);
        shp(8'h07, 1'b1, 91, 3125);
        shp(8'h08, 1'b1, 1562, 3125);
        shp(8'h10, 1'b1, 48, 3125);
        shp(8'h05, 1'b1, 0, 0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
